// *** rtl/cpu_status_word_flags.sv ***
// Processor status word register with flag update logic
// Function
// - Bits 31 to 8 always read zero; writes there ignored.
// - Bit 7 set on accepted NMI; blocks nested interrupts.
// - Bit 6 set on exception; does not block interrupts.
// - Bit 5 at one blocks every maskable interrupt.
// - Bit 4 is sticky: set on clamp, kept when no clamp.
// - Bit 4 sets only when a saturating operation overflows or a load writes one there.
// - Bit 3 follows carry or borrow of the operation.
// - Bit 2 follows signed overflow of the operation.
// - Bit 1 follows result sign.
// - Bit 0 is one exactly when the result is zero.
// - Positive clamp: sticky, overflow set, sign clear, max positive.
// - Negative clamp: sticky, overflow, sign set, max negative.
// - In range: sticky kept, overflow clear, sign from result.
// - Loaded word effective next cycle; only the old mask, not the loaded one, blocks irq during load.
`timescale 1ns/1ps
module cpu_status_word_flags
  import psw_pkg::*;
(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // Arithmetic result
  input  wire logic                       alu_valid,
  input  wire logic                       alu_saturating,
  input  wire logic [psw_pkg::WORD_W-1:0] alu_result,
  input  wire logic                       alu_carry,
  input  wire logic                       alu_wrap,
  input  wire logic                       upd_zero,
  input  wire logic                       upd_sign,
  input  wire logic                       upd_wrap,
  input  wire logic                       upd_carry,
  // System register access
  input  wire logic                       sysreg_load_instr,
  input  wire logic [psw_pkg::WORD_W-1:0] sysreg_wdata,
  // Events
  input  wire logic                       exception_evt,
  input  wire logic                       nmi_req,
  input  wire logic                       irq_req,
  // Outputs
  output logic      [psw_pkg::WORD_W-1:0] program_status_word,
  output logic      [psw_pkg::WORD_W-1:0] op_result,
  output logic                            nmi_accept,
  output logic                            irq_accept
);
  import psw_pkg::*;

  // ----------------------------------------------------------------
  // Saturation clamp
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] sat_result;
  logic              sat_wrap;
  logic              sat_sign;
  logic              sat_zero;
  logic [LIVE_W-1:0] psw_q;
  logic [LIVE_W-1:0] psw_d;
  logic [WORD_W-1:0] res_q;
  logic [WORD_W-1:0] res_d;

  sat_clamp u_sat_clamp (
    .raw_result (alu_result),
    .raw_wrap   (alu_wrap),
    .sat_result (sat_result),
    .sat_wrap   (sat_wrap),
    .sat_sign   (sat_sign),
    .sat_zero   (sat_zero)
  );

  // ----------------------------------------------------------------
  // Interrupt gate
  // ----------------------------------------------------------------
  irq_gate u_irq_gate (
    .nmi_req           (nmi_req),
    .irq_req           (irq_req),
    .nmi_in_service    (psw_q[BIT_NMI]),
    .maskable_irq_mask (psw_q[BIT_IRQ_MASK]),
    .load_busy         (sysreg_load_instr),
    .nmi_accept        (nmi_accept),
    .irq_accept        (irq_accept)
  );

  // ----------------------------------------------------------------
  // Next status word
  // ----------------------------------------------------------------
  always_comb begin
    psw_d = psw_q;
    res_d = res_q;
    if (sysreg_load_instr) begin
      // Load wins over a same-cycle result; upper bits dropped
      psw_d = sysreg_wdata[LIVE_W-1:0];
    end else if (alu_valid && alu_saturating) begin
      res_d = sat_result;
      psw_d[BIT_WRAP] = sat_wrap;
      psw_d[BIT_SIGN] = sat_sign;
      psw_d[BIT_ZERO] = sat_zero;
      if (sat_wrap) begin
        psw_d[BIT_CLAMP] = 1'b1;
      end
      if (upd_carry) begin
        psw_d[BIT_CARRY] = alu_carry;
      end
    end else if (alu_valid) begin
      res_d = alu_result;
      // Bit 4 left alone on plain arithmetic
      if (upd_carry) begin
        psw_d[BIT_CARRY] = alu_carry;
      end
      if (upd_wrap) begin
        psw_d[BIT_WRAP] = alu_wrap;
      end
      if (upd_sign) begin
        psw_d[BIT_SIGN] = alu_result[WORD_W-1];
      end
      if (upd_zero) begin
        psw_d[BIT_ZERO] = (alu_result == '0);
      end
    end
    // Hardware events set over any same-cycle load
    if (exception_evt) begin
      psw_d[BIT_TRAP] = 1'b1;
    end
    if (nmi_accept) begin
      psw_d[BIT_NMI] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      psw_q <= PSW_RESET[LIVE_W-1:0];
      res_q <= '0;
    end else begin
      psw_q <= psw_d;
      res_q <= res_d;
    end
  end

  assign program_status_word = {{(WORD_W-LIVE_W){1'b0}}, psw_q};
  assign op_result           = res_q;
endmodule : cpu_status_word_flags

// *** rtl/irq_gate.sv ***
// Interrupt acceptance gate steered by the status word
`timescale 1ns/1ps
module irq_gate (
  // Requests
  input  wire logic nmi_req,
  input  wire logic irq_req,
  // Status word state
  input  wire logic nmi_in_service,
  input  wire logic maskable_irq_mask,
  input  wire logic load_busy,
  // Acceptance
  output logic      nmi_accept,
  output logic      irq_accept
);
  always_comb begin
    // Trap state is deliberately not an input: it never blocks requests
    nmi_accept = nmi_req && !nmi_in_service;
    irq_accept = irq_req && !nmi_req && !nmi_in_service
                 && !maskable_irq_mask
                 && !(load_busy && maskable_irq_mask);
  end
endmodule : irq_gate

// *** rtl/psw_pkg.sv ***
// Constants and types shared by the status word block
package psw_pkg;
  localparam int unsigned      WORD_W          = 32;
  localparam int unsigned      LIVE_W          = 8;
  localparam logic [31:0]      PSW_RESET       = 32'h0000_0021;
  localparam int unsigned      BIT_ZERO        = 0;
  localparam int unsigned      BIT_SIGN        = 1;
  localparam int unsigned      BIT_WRAP        = 2;
  localparam int unsigned      BIT_CARRY       = 3;
  localparam int unsigned      BIT_CLAMP       = 4;
  localparam int unsigned      BIT_IRQ_MASK    = 5;
  localparam int unsigned      BIT_TRAP        = 6;
  localparam int unsigned      BIT_NMI         = 7;
  localparam logic [31:0]      SAT_POS_LIMIT   = 32'h7FFF_FFFF;
  localparam logic [31:0]      SAT_NEG_LIMIT   = 32'h8000_0000;
endpackage : psw_pkg

// *** rtl/sat_clamp.sv ***
// Saturating result clamp and its flag outcome
`timescale 1ns/1ps
module sat_clamp
  import psw_pkg::*;
(
  // Raw operation result
  input  wire logic [psw_pkg::WORD_W-1:0] raw_result,
  input  wire logic                       raw_wrap,
  // Clamped result and flags
  output logic      [psw_pkg::WORD_W-1:0] sat_result,
  output logic                            sat_wrap,
  output logic                            sat_sign,
  output logic                            sat_zero
);
  import psw_pkg::*;

  always_comb begin
    sat_wrap = raw_wrap;
    if (raw_wrap && !raw_result[WORD_W-1]) begin
      // Wrapped to non-negative means true result was below minimum
      sat_result = SAT_NEG_LIMIT;
      sat_sign   = 1'b1;
    end else if (raw_wrap) begin
      sat_result = SAT_POS_LIMIT;
      sat_sign   = 1'b0;
    end else begin
      sat_result = raw_result;
      sat_sign   = raw_result[WORD_W-1];
    end
    sat_zero = (sat_result == '0);
  end
endmodule : sat_clamp

// *** testbench/cpu_status_word_flags_test.sv ***
// Self-checking bench for the status word block
`timescale 1ns/1ps
module cpu_status_word_flags_test;
  import psw_pkg::*;
  logic        sys_clk = 0, rst = 1, alu_valid = 0, alu_saturating = 0;
  logic        alu_wrap = 0, alu_carry = 0, upd_zero = 0, upd_sign = 0;
  logic        upd_wrap = 0, upd_carry = 0, sysreg_load_instr = 0;
  logic        exception_evt = 0, raise_nmi = 0, raise_irq = 0;
  logic        nmi_req, irq_req, nmi_accept, irq_accept;
  logic [31:0] alu_result = 0, sysreg_wdata = 0, program_status_word;
  logic [31:0] op_result, acc = 0;
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  always #4 sys_clk = ~sys_clk;
  cpu_status_word_flags i_cpu_status_word_flags (.*);
  irq_source i_irq_source (.*);
  task chk(logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %0t got %h exp %h", $time, g, e);
    end
  endtask
  task op(logic s, w, c, u, logic [31:0] r, e, p);
    @(posedge sys_clk);
    {alu_valid, alu_saturating, alu_wrap, alu_carry} <= {1'b1, s, w, c};
    {upd_zero, upd_sign, upd_wrap, upd_carry} <= {4{u}};
    alu_result <= r;
    @(posedge sys_clk);
    alu_valid <= 0;
    #1 chk(program_status_word, e);
    chk(op_result, p);
  endtask
  // Pulse load, trap, nmi, irq; accepted irqs are counted in acc
  task ev(logic [3:0] k, logic [31:0] d, e, n);
    @(posedge sys_clk);
    {sysreg_load_instr, exception_evt, raise_nmi, raise_irq} <= k;
    sysreg_wdata <= d;
    @(posedge sys_clk);
    {sysreg_load_instr, exception_evt, raise_nmi, raise_irq} <= 4'h0;
    repeat (2) @(posedge sys_clk);
    #1 chk(program_status_word, e);
    chk(acc, n);
  endtask
  task t_alu;
    op(0, 0, 1, 1, 32'h0, 32'h29, 32'h0);
    op(0, 1, 0, 1, SAT_NEG_LIMIT, 32'h26, SAT_NEG_LIMIT);
    op(0, 0, 1, 0, 32'h0, 32'h26, 32'h0);
    op(1, 1, 0, 1, 32'h8000_0001, 32'h34, SAT_POS_LIMIT);
    op(1, 1, 0, 1, SAT_POS_LIMIT, 32'h36, SAT_NEG_LIMIT);
    op(1, 0, 0, 1, 32'h5, 32'h30, 32'h5);
    op(0, 0, 0, 1, 32'h3, 32'h30, 32'h3);
  endtask
  task t_irq;
    ev(4'h8, 32'hFFFF_FF20, 32'h20, 32'h0);
    ev(4'h1, 32'h0, 32'h20, 32'h0);
    ev(4'h8, 32'h0, 32'h0, 32'h1);
    ev(4'h5, 32'h0, 32'h40, 32'h2);
    ev(4'h2, 32'h0, 32'hC0, 32'h2);
    ev(4'h1, 32'h0, 32'hC0, 32'h2);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    acc <= acc + 32'(irq_accept === 1'b1);
    if (cyc == 400) begin
      error_cnt++;
      end_sim;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    #1 chk(program_status_word, PSW_RESET);
    t_alu;
    t_irq;
    end_sim;
  end
endmodule // cpu_status_word_flags_test

// *** testbench/irq_source.sv ***
// Interrupt source model: a request stays up until it is accepted
`timescale 1ns/1ps
module irq_source (
  input  wire logic sys_clk, rst, raise_nmi, raise_irq, nmi_accept, irq_accept,
  output logic      nmi_req, irq_req);
  always_ff @(posedge sys_clk) begin
    nmi_req <= !rst && (raise_nmi || nmi_req && !nmi_accept);
    irq_req <= !rst && (raise_irq || irq_req && !irq_accept);
  end
endmodule // irq_source

// *** testbench/psw_monitor.sv ***
// Port checks for the status word block
`timescale 1ns/1ps
module psw_monitor (
  input wire logic        sys_clk, rst, alu_valid, alu_saturating, alu_wrap,
  input wire logic        sysreg_load_instr, exception_evt, nmi_accept,
  input wire logic        irq_accept,
  input wire logic [31:0] alu_result, sysreg_wdata, program_status_word,
  input wire logic [31:0] op_result);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire [31:0] w = program_status_word;
  wire        m = alu_result[31];
  wire        v = alu_valid && !sysreg_load_instr;
  wire        s = v && alu_saturating;
  wire        l = sysreg_load_instr && !exception_evt && !nmi_accept;
  property p_nmi; nmi_accept |=> w[7]; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi");
  property p_blk; w[7] |-> !irq_accept && !nmi_accept; endproperty
  a_blk: assert property (p_blk) else $error("nest");
  property p_exc; exception_evt |=> w[6]; endproperty
  a_exc: assert property (p_exc) else $error("trap");
  property p_msk; w[5] |-> !irq_accept; endproperty
  a_msk: assert property (p_msk) else $error("mask");
  property p_ld; l |=> w == {24'h0, $past(sysreg_wdata[7:0])}; endproperty
  a_ld: assert property (p_ld) else $error("load");
  property p_sat; s && alu_wrap |=> {w[4], w[2], w[1]} == {2'b11, !$past(m)}
    && op_result == {!$past(m), {31{$past(m)}}}; endproperty
  a_sat: assert property (p_sat) else $error("clamp");
  property p_in; s && !alu_wrap |=> !w[2] && $stable(w[4])
    && op_result == $past(alu_result); endproperty
  a_in: assert property (p_in) else $error("range");
  property p_keep; v && !alu_saturating |=> $stable(w[4]); endproperty
  a_keep: assert property (p_keep) else $error("sticky");
  c_sat: cover property (s && alu_wrap);
  c_irq: cover property (irq_accept);
  c_nmi: cover property (nmi_accept);
endmodule // psw_monitor
bind cpu_status_word_flags psw_monitor i_psw_monitor (.*);
